// ---- rtl/ftp_pkg.sv ----
// shared constants for the frame timing policy block
package ftp_pkg;
    // register byte offsets on the apb slave
    localparam logic [7:0] FTP_REG_CTRL = 8'h00;
    localparam logic [7:0] FTP_REG_CYCREP = 8'h04;
    localparam logic [7:0] FTP_REG_TXDATA = 8'h08;
    localparam logic [7:0] FTP_REG_TXNULL = 8'h0C;
    localparam logic [7:0] FTP_REG_LINSCHED = 8'h10;
    localparam logic [7:0] FTP_REG_STATUS = 8'h14;
    localparam logic [7:0] FTP_REG_SIGVAL = 8'h18;
    // control register field positions
    localparam int FTP_CTRL_LIN = 0;
    localparam int FTP_CTRL_DYN = 1;
    localparam int FTP_CTRL_EVT = 2;
    localparam int FTP_CTRL_MULTI = 3;
    localparam int FTP_CTRL_FWDNULL = 4;
    localparam int FTP_CTRL_STREAM = 5;
    // status register field positions
    localparam int FTP_ST_PENDING = 0;
    localparam int FTP_ST_RUNNING = 1;
    localparam int FTP_ST_MASTER = 2;
    localparam int FTP_ST_NULLDROP = 3;
    localparam int FTP_ST_STREAMREJ = 4;
    // reset values
    localparam logic [7:0] FTP_CYCREP_RST = 8'h01;
    localparam logic [31:0] FTP_PAYLOAD_RST = 32'h0000_0000;
    // timing: core clock period and lin header spacing when master
    localparam int FTP_CLK_PERIOD_NS = 10;
    localparam int FTP_LIN_HDR_PERIOD_US = 1000;
    localparam int FTP_LIN_HDR_CYC = FTP_LIN_HDR_PERIOD_US * 1000 / FTP_CLK_PERIOD_NS;
    // lin role, one-hot
    typedef enum logic [1:0] {
        FTP_LIN_SLAVE = 2'b01,
        FTP_LIN_MASTER = 2'b10
    } ftp_lin_t;
endpackage : ftp_pkg

// ---- rtl/ftp_tick_div.sv ----
// clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module ftp_tick_div #(
    parameter int DIV = 100000
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    output logic tick_o
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt;

    // counter restarts whenever disabled so the first tick lands a full period later
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (!en_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt == LAST);
            cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
        end
    end
endmodule : ftp_tick_div
`default_nettype wire

// ---- rtl/ftp_frame_policy.sv ----
// per-frame transmit and receive timing policy with apb registers
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ftp_frame_policy
    import ftp_pkg::*;
#(
    parameter int HDR_PERIOD_CYC = FTP_LIN_HDR_CYC,
    parameter int DW = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // protocol engine side, same clock
    input wire logic normal_active_i,
    input wire logic cycle_start_i,
    input wire logic slot_i,
    input wire logic lin_header_i,
    input wire logic rx_valid_i,
    input wire logic rx_null_i,
    input wire logic [DW-1:0] rx_data_i,
    // transmit decisions
    output logic tx_data_o,
    output logic tx_null_o,
    output logic [DW-1:0] tx_payload_o,
    output logic lin_hdr_o,
    output logic lin_master_o,
    // receive deliveries
    output logic [DW-1:0] sig_val_o,
    output logic [DW-1:0] rx_out_o,
    output logic frm_dlv_o,
    output logic strm_dlv_o,
    output logic strm_null_o
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic is_lin;
        logic dyn_seg;
        logic evt_timing;
        logic multi_rep;
        logic fwd_null;
        logic stream_on;
        logic [7:0] cyc_rep;
        logic [7:0] cyc_cnt;
        logic slot_seen;
        logic [DW-1:0] tx_buf;
        logic pending;
        logic null_drop;
        logic stream_rej;
        ftp_lin_t lin_st;
        logic tx_data;
        logic tx_null;
        logic [DW-1:0] tx_payload;
        logic lin_hdr;
        logic [DW-1:0] sig_val;
        logic [DW-1:0] rx_out;
        logic frm_dlv;
        logic strm_dlv;
        logic strm_null;
    } ftp_state_t;

    ftp_state_t st;
    ftp_state_t next_st;
    logic hdr_tick;
    logic wr_acc;
    logic host_wr;
    logic tx_opp;
    logic rate_ok;

    // address decode for the error answer; the read mux has its own case
    function automatic logic ftp_mapped(input logic [7:0] a);
        return (a == FTP_REG_CTRL) || (a == FTP_REG_CYCREP) || (a == FTP_REG_TXDATA) ||
            (a == FTP_REG_TXNULL) || (a == FTP_REG_LINSCHED) || (a == FTP_REG_STATUS) ||
            (a == FTP_REG_SIGVAL);
    endfunction : ftp_mapped

    // master header pacing; idle while slave so no stray headers go out
    ftp_tick_div #(
        .DIV(HDR_PERIOD_CYC)
    ) u_hdr_div (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .en_i(st.lin_st == FTP_LIN_MASTER && normal_active_i),
        .tick_o(hdr_tick)
    );

    // a write takes effect only at the access edge where pready is high
    assign wr_acc = psel_i && penable_i && st.pready && pwrite_i;
    assign host_wr = wr_acc && (paddr_i == FTP_REG_TXDATA);

    // transmit opportunity for this frame
    always_comb begin
        rate_ok = st.dyn_seg || (st.cyc_cnt == 8'h00);
        if (st.is_lin) begin
            // master answers its own header, slave waits for the remote one
            if (st.lin_st == FTP_LIN_MASTER) begin
                tx_opp = hdr_tick && normal_active_i;
            end else begin
                tx_opp = lin_header_i && normal_active_i;
            end
        end else begin
            // dynamic and single-rate static frames take one slot per cycle
            tx_opp = slot_i && normal_active_i && rate_ok &&
                ((st.multi_rep && !st.dyn_seg) || !st.slot_seen);
        end
    end

    // whole next-state computation
    always_comb begin
        next_st = st;
        next_st.tx_data = 1'b0;
        next_st.tx_null = 1'b0;
        next_st.lin_hdr = 1'b0;
        next_st.frm_dlv = 1'b0;
        next_st.strm_dlv = 1'b0;
        // apb: pready comes one cycle after setup, giving a single access cycle
        next_st.pready = psel_i && !penable_i;
        next_st.pslverr = psel_i && !penable_i && !ftp_mapped(paddr_i);
        if (psel_i && !penable_i) begin
            unique case (paddr_i)
                FTP_REG_CTRL: next_st.prdata = {26'h0, st.stream_on, st.fwd_null,
                    st.multi_rep, st.evt_timing, st.dyn_seg, st.is_lin};
                FTP_REG_CYCREP: next_st.prdata = {24'h0, st.cyc_rep};
                FTP_REG_TXDATA: next_st.prdata = 32'(st.tx_buf);
                FTP_REG_STATUS: next_st.prdata = {27'h0, st.stream_rej, st.null_drop,
                    st.lin_st == FTP_LIN_MASTER, normal_active_i, st.pending};
                FTP_REG_SIGVAL: next_st.prdata = 32'(st.sig_val);
                default: next_st.prdata = 32'h0000_0000;
            endcase
        end
        // register writes
        if (wr_acc) begin
            unique case (paddr_i)
                FTP_REG_CTRL: begin
                    next_st.is_lin = pwdata_i[FTP_CTRL_LIN];
                    next_st.dyn_seg = pwdata_i[FTP_CTRL_DYN];
                    next_st.evt_timing = pwdata_i[FTP_CTRL_EVT];
                    next_st.multi_rep = pwdata_i[FTP_CTRL_MULTI];
                    next_st.fwd_null = pwdata_i[FTP_CTRL_FWDNULL];
                    // stream transmit only exists on lin
                    next_st.stream_on = pwdata_i[FTP_CTRL_STREAM] && pwdata_i[FTP_CTRL_LIN];
                    if (pwdata_i[FTP_CTRL_STREAM] && !pwdata_i[FTP_CTRL_LIN]) begin
                        next_st.stream_rej = 1'b1;
                    end
                end
                FTP_REG_CYCREP: begin
                    // zero is not kept; it is stored as one, the reset value
                    next_st.cyc_rep = (pwdata_i[7:0] == 8'h00) ? FTP_CYCREP_RST : pwdata_i[7:0];
                    next_st.cyc_cnt = 8'h00;
                end
                FTP_REG_TXDATA: begin
                    next_st.tx_buf = pwdata_i[DW-1:0];
                    next_st.pending = 1'b1;
                end
                FTP_REG_TXNULL: next_st.null_drop = 1'b1;
                FTP_REG_LINSCHED: next_st.lin_st = FTP_LIN_MASTER;
                FTP_REG_STATUS: begin
                    // write one to clear; a same-cycle set below still wins
                    if (pwdata_i[FTP_ST_NULLDROP]) begin
                        next_st.null_drop = 1'b0;
                    end
                    if (pwdata_i[FTP_ST_STREAMREJ]) begin
                        next_st.stream_rej = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // host null writes are never queued; flag again if cleared in the same cycle
        if (wr_acc && paddr_i == FTP_REG_TXNULL) begin
            next_st.null_drop = 1'b1;
        end
        if (wr_acc && paddr_i == FTP_REG_CTRL && pwdata_i[FTP_CTRL_STREAM] &&
            !pwdata_i[FTP_CTRL_LIN]) begin
            next_st.stream_rej = 1'b1;
        end
        // cycle bookkeeping for the repetition rate
        if (cycle_start_i) begin
            next_st.slot_seen = 1'b0;
            next_st.cyc_cnt = (st.cyc_cnt + 8'h01 >= st.cyc_rep) ? 8'h00 : st.cyc_cnt + 8'h01;
        end else if (slot_i) begin
            next_st.slot_seen = 1'b1;
        end
        // master header issue
        if (st.lin_st == FTP_LIN_MASTER && hdr_tick && normal_active_i) begin
            next_st.lin_hdr = 1'b1;
        end
        // transmit decision at the frame's opportunity
        if (tx_opp) begin
            if (!st.evt_timing) begin
                // cyclic: always data, old payload when nothing new
                next_st.tx_data = 1'b1;
                next_st.tx_payload = st.tx_buf;
                next_st.pending = host_wr;
            end else if (st.pending) begin
                next_st.tx_data = 1'b1;
                next_st.tx_payload = st.tx_buf;
                next_st.pending = host_wr;
            end else if (!st.dyn_seg && !st.is_lin) begin
                next_st.tx_null = 1'b1;
            end
            // dynamic or lin event frame with nothing new stays silent
        end
        // receive paths: nulls never reach signals or per-frame queues
        if (rx_valid_i) begin
            next_st.rx_out = rx_data_i;
            if (!rx_null_i) begin
                next_st.sig_val = rx_data_i;
                next_st.frm_dlv = 1'b1;
                next_st.strm_dlv = 1'b1;
                next_st.strm_null = 1'b0;
            end else if (st.fwd_null && !st.is_lin) begin
                next_st.strm_dlv = 1'b1;
                next_st.strm_null = 1'b1;
            end
        end
    end

    // single state register
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{
                pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
                is_lin: 1'b0, dyn_seg: 1'b0, evt_timing: 1'b0, multi_rep: 1'b0,
                fwd_null: 1'b0, stream_on: 1'b0,
                cyc_rep: FTP_CYCREP_RST, cyc_cnt: 8'h00, slot_seen: 1'b0,
                tx_buf: FTP_PAYLOAD_RST[DW-1:0], pending: 1'b0,
                null_drop: 1'b0, stream_rej: 1'b0, lin_st: FTP_LIN_SLAVE,
                tx_data: 1'b0, tx_null: 1'b0, tx_payload: FTP_PAYLOAD_RST[DW-1:0],
                lin_hdr: 1'b0, sig_val: FTP_PAYLOAD_RST[DW-1:0],
                rx_out: FTP_PAYLOAD_RST[DW-1:0], frm_dlv: 1'b0, strm_dlv: 1'b0,
                strm_null: 1'b0
            };
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign tx_data_o = st.tx_data;
    assign tx_null_o = st.tx_null;
    assign tx_payload_o = st.tx_payload;
    assign lin_hdr_o = st.lin_hdr;
    assign lin_master_o = st.lin_st[1]; // master bit of the one-hot role, no gate after the flop
    assign sig_val_o = st.sig_val;
    assign rx_out_o = st.rx_out;
    assign frm_dlv_o = st.frm_dlv;
    assign strm_dlv_o = st.strm_dlv;
    assign strm_null_o = st.strm_null;

    // checks on the policy
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_null_only_evt: assert property (tx_null_o |-> $past(st.evt_timing && !st.dyn_seg && !st.is_lin))
        else $error("null frame sent outside event static frame");
    a_dyn_evt_silent: assert property ((tx_opp && st.evt_timing && (st.dyn_seg || st.is_lin)
        && !st.pending) |=> !tx_data_o && !tx_null_o)
        else $error("event frame sent without pending data");
    a_static_evt_null: assert property ((tx_opp && st.evt_timing && !st.dyn_seg && !st.is_lin
        && !st.pending) |=> tx_null_o && !tx_data_o)
        else $error("missing null frame in static slot");
    a_cyclic_data: assert property ((tx_opp && !st.evt_timing) |=> tx_data_o
        && tx_payload_o == $past(st.tx_buf))
        else $error("cyclic frame not resent");
    a_evt_clears: assert property ((tx_opp && st.evt_timing && st.pending && !host_wr)
        |=> !st.pending ##1 (!tx_data_o || st.pending || $past(tx_opp, 1) == 1'b0))
        else $error("event frame pending not cleared");
    a_not_running: assert property (!normal_active_i |=> !tx_data_o && !tx_null_o)
        else $error("frame sent before normal active");
    a_rx_null_drop: assert property ((rx_valid_i && rx_null_i) |=> $stable(sig_val_o)
        && !frm_dlv_o)
        else $error("null frame reached signal or frame path");
    a_strm_null_fwd: assert property ((rx_valid_i && rx_null_i) |=> strm_dlv_o
        == $past(st.fwd_null && !st.is_lin))
        else $error("stream null forwarding wrong");
    a_strm_type: assert property (strm_dlv_o |-> strm_null_o == $past(rx_null_i))
        else $error("stream entry type wrong");
    a_no_fr_stream: assert property (!st.is_lin |-> !st.stream_on)
        else $error("stream transmit enabled on time-triggered bus");
    a_sched_master: assert property ((wr_acc && paddr_i == FTP_REG_LINSCHED) |=> lin_master_o)
        else $error("schedule write did not make master");
    a_slave_waits: assert property ((tx_data_o && $past(st.is_lin
        && st.lin_st == FTP_LIN_SLAVE)) |-> $past(lin_header_i))
        else $error("slave response without header");
    a_static_rate: assert property ((tx_data_o && $past(!st.dyn_seg && !st.is_lin))
        |-> $past(st.cyc_cnt) == 8'h00)
        else $error("static frame sent off its repetition");

    c_evt_send: cover property (st.pending ##[1:50] tx_data_o);
    c_null_sent: cover property (tx_null_o);
    c_null_fwd: cover property (strm_dlv_o && strm_null_o);
    c_master_hdr: cover property (lin_hdr_o);
endmodule : ftp_frame_policy
`default_nettype wire

// ---- dv/ftp_bus_model.sv ----
// protocol engine and bus node model feeding the frame timing policy block
`timescale 1ns/1ps
`default_nettype none
module ftp_bus_model (
    input wire logic core_clk_i,
    output logic cycle_start_o,
    output logic slot_o,
    output logic lin_header_o,
    output logic rx_valid_o,
    output logic rx_null_o,
    output logic [31:0] rx_data_o
);
    // idle levels; data lines carry noise the block must ignore while valid is low
    task automatic idle();
        cycle_start_o <= 1'b0;
        slot_o <= 1'b0;
        lin_header_o <= 1'b0;
        rx_valid_o <= 1'b0;
        rx_null_o <= 1'($urandom());
        rx_data_o <= $urandom();
    endtask : idle
    // one communication cycle with n openings; spacing keeps results apart
    task automatic run_cycle(input int n);
        cycle_start_o <= 1'b1;
        @(posedge core_clk_i);
        cycle_start_o <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        for (int i = 0; i < n; i++) begin
            slot_o <= 1'b1;
            @(posedge core_clk_i);
            slot_o <= 1'b0;
            repeat (4) @(posedge core_clk_i);
        end
    endtask : run_cycle
    // header of a remote master; this block is the single responder
    task automatic header();
        lin_header_o <= 1'b1;
        @(posedge core_clk_i);
        lin_header_o <= 1'b0;
        repeat (4) @(posedge core_clk_i);
    endtask : header
    // received frame; afterwards the lines show the inverse, never a stale copy
    task automatic rx(input logic is_null, input logic [31:0] d);
        rx_valid_o <= 1'b1;
        rx_null_o <= is_null;
        rx_data_o <= d;
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        rx_null_o <= ~is_null;
        rx_data_o <= ~d;
        repeat (4) @(posedge core_clk_i);
    endtask : rx
endmodule : ftp_bus_model
`default_nettype wire

// ---- dv/ftp_frame_policy_bench.sv ----
// self-checking bench for the frame timing policy block
`timescale 1ns/1ps
`default_nettype none
module ftp_frame_policy_bench
    import ftp_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_b_i, psel_i, penable_i, pwrite_i, normal_active_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o, tx_payload_o, sig_val_o, rx_out_o, rx_data_i;
    logic pready_o, pslverr_o, tx_data_o, tx_null_o, lin_hdr_o, lin_master_o;
    logic frm_dlv_o, strm_dlv_o, strm_null_o, cycle_start_i, slot_i;
    logic lin_header_i, rx_valid_i, rx_null_i;
    logic [35:0] exp_q[$];
    logic [31:0] p;
    int fails = 0;
    int cmp_count = 0;
    always #5 core_clk_i = ~core_clk_i;
    ftp_frame_policy #(.HDR_PERIOD_CYC(8), .DW(32)) i_dut (.core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .normal_active_i(normal_active_i),
        .cycle_start_i(cycle_start_i), .slot_i(slot_i), .lin_header_i(lin_header_i),
        .rx_valid_i(rx_valid_i), .rx_null_i(rx_null_i), .rx_data_i(rx_data_i),
        .tx_data_o(tx_data_o), .tx_null_o(tx_null_o), .tx_payload_o(tx_payload_o),
        .lin_hdr_o(lin_hdr_o), .lin_master_o(lin_master_o), .sig_val_o(sig_val_o),
        .rx_out_o(rx_out_o), .frm_dlv_o(frm_dlv_o), .strm_dlv_o(strm_dlv_o),
        .strm_null_o(strm_null_o));
    ftp_bus_model i_bus (.core_clk_i(core_clk_i), .cycle_start_o(cycle_start_i),
        .slot_o(slot_i), .lin_header_o(lin_header_i), .rx_valid_o(rx_valid_i),
        .rx_null_o(rx_null_i), .rx_data_o(rx_data_i));
    task automatic note(input logic [3:0] c, input logic [31:0] v);
        exp_q.push_back({c, v});
    endtask : note
    // compare one observed result with the oldest note
    task automatic see(input logic [3:0] c, input logic [31:0] v);
        logic [35:0] e;
        cmp_count++;
        if (exp_q.size() == 0) begin
            fails++;
            $display("wrong value result: expected none, seen %h", {c, v});
        end else begin
            e = exp_q.pop_front();
            if (e !== {c, v}) begin
                fails++;
                $display("wrong value result: expected %h, seen %h", e, {c, v});
            end
        end
    endtask : see
    // direct check of a level output that the queue never sees
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", nm, e, s);
        end
    endtask : chk
    // watcher at the falling edge, where registered one-cycle outputs are settled
    always @(negedge core_clk_i) begin
        if ((tx_data_o | tx_null_o | lin_hdr_o) !== 1'b0)
            see({1'b0, lin_hdr_o, tx_null_o, tx_data_o}, tx_payload_o & {32{tx_data_o}});
        if ((frm_dlv_o | strm_dlv_o) !== 1'b0)
            see({1'b1, frm_dlv_o, strm_dlv_o, strm_null_o}, rx_out_o & {32{~strm_null_o}});
        if (pready_o === 1'b1 && pwrite_i === 1'b0)
            see({3'b010, pslverr_o}, prdata_o);
    end
    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
        note({3'b010, err}, d);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // every noted result must have shown up; leftovers mean a missing frame
    task automatic drain();
        repeat (40) if (exp_q.size() != 0) @(posedge core_clk_i);
        cmp_count++;
        if (exp_q.size() != 0) begin
            fails++;
            $display("wrong value open results: expected 0, seen %0d", exp_q.size());
            exp_q.delete();
        end
    endtask : drain
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        end_of_test();
    end
    initial begin
        void'($urandom(63309));
        rst_b_i <= 1'b0;
        {psel_i, penable_i, normal_active_i} <= 3'b000;
        pwrite_i <= 1'($urandom());
        paddr_i <= 8'($urandom());
        pwdata_i <= $urandom();
        i_bus.idle();
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        rd(FTP_REG_CYCREP, 32'h0000_0001, 1'b0);
        chk("lin_master", 32'h0000_0000, 32'(lin_master_o));
        rd(FTP_REG_STATUS, 32'h0000_0000, 1'b0);
        rd(8'h20, 32'h0000_0000, 1'b1);
        p = $urandom();
        wr(FTP_REG_TXDATA, p);
        i_bus.run_cycle(1);
        drain();
        // cyclic static: pending data, then repeats, host null dropped
        normal_active_i <= 1'b1;
        repeat (3) note(4'h1, p);
        repeat (2) i_bus.run_cycle(1);
        wr(FTP_REG_TXNULL, ~p);
        i_bus.run_cycle(1);
        rd(FTP_REG_STATUS, 32'h0000_000A, 1'b0);
        wr(FTP_REG_STATUS, 32'h0000_0008);
        rd(FTP_REG_STATUS, 32'h0000_0002, 1'b0);
        wr(FTP_REG_CYCREP, 32'h0000_0000);
        rd(FTP_REG_CYCREP, 32'h0000_0001, 1'b0);
        // repetition 3 over six cycles gives two frames whatever the phase
        wr(FTP_REG_CYCREP, 32'h0000_0003);
        repeat (2) note(4'h1, p);
        repeat (6) i_bus.run_cycle(1);
        drain();
        wr(FTP_REG_CYCREP, 32'h0000_0001);
        wr(FTP_REG_CTRL, 32'h0000_0008);
        repeat (2) note(4'h1, p);
        i_bus.run_cycle(2);
        wr(FTP_REG_CTRL, 32'h0000_0002);
        repeat (2) note(4'h1, p);
        repeat (2) i_bus.run_cycle(2);
        drain();
        // event static: newest write wins, then null when nothing new
        wr(FTP_REG_CTRL, 32'h0000_0004);
        wr(FTP_REG_TXDATA, ~p);
        p = $urandom();
        wr(FTP_REG_TXDATA, p);
        rd(FTP_REG_STATUS, 32'h0000_0003, 1'b0);
        note(4'h1, p);
        repeat (2) note(4'h2, 32'h0000_0000);
        repeat (2) i_bus.run_cycle(1);
        wr(FTP_REG_TXNULL, p);
        i_bus.run_cycle(1);
        wr(FTP_REG_STATUS, 32'h0000_0008);
        // event dynamic: minislot used only with fresh data, once per cycle
        wr(FTP_REG_CTRL, 32'h0000_0006);
        i_bus.run_cycle(1);
        p = $urandom();
        wr(FTP_REG_TXDATA, p);
        note(4'h1, p);
        i_bus.run_cycle(2);
        i_bus.run_cycle(1);
        drain();
        // receive: data delivered, nulls dropped unless forwarding is on
        wr(FTP_REG_CTRL, 32'h0000_0000);
        note(4'hE, ~p);
        i_bus.rx(1'b0, ~p);
        i_bus.rx(1'b1, p);
        wr(FTP_REG_CTRL, 32'h0000_0010);
        note(4'hB, 32'h0000_0000);
        i_bus.rx(1'b1, p);
        rd(FTP_REG_SIGVAL, ~p, 1'b0);
        chk("sig_val", ~p, sig_val_o);
        wr(FTP_REG_CTRL, 32'h0000_0020);
        rd(FTP_REG_CTRL, 32'h0000_0000, 1'b0);
        rd(FTP_REG_STATUS, 32'h0000_0012, 1'b0);
        wr(FTP_REG_STATUS, 32'h0000_0010);
        drain();
        // stream transmit sticks on lin; then lin slave waits for headers and repeats
        wr(FTP_REG_CTRL, 32'h0000_0021);
        rd(FTP_REG_CTRL, 32'h0000_0021, 1'b0);
        wr(FTP_REG_CTRL, 32'h0000_0001);
        p = $urandom();
        wr(FTP_REG_TXDATA, p);
        i_bus.run_cycle(2);
        repeat (2) note(4'h1, p);
        i_bus.header();
        i_bus.header();
        drain();
        // master: three headers, each answered by this block in the same cycle
        normal_active_i <= 1'b0;
        wr(FTP_REG_LINSCHED, 32'h0000_0001);
        rd(FTP_REG_STATUS, 32'h0000_0004, 1'b0);
        chk("lin_master", 32'h0000_0001, 32'(lin_master_o));
        repeat (3) note(4'h5, p);
        normal_active_i <= 1'b1;
        repeat (40) if (exp_q.size() != 0) @(posedge core_clk_i);
        normal_active_i <= 1'b0;
        drain();
        end_of_test();
    end
endmodule : ftp_frame_policy_bench
`default_nettype wire
